//--- rtl/dpc_pkg.sv
// package: register map, reset values and timing for the pid speed controller
package dpc_pkg;
	// ****************
	// register offsets
	// ****************
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_SETPOINT = 8'h04;
	localparam logic [7:0] OFS_KP = 8'h08;
	localparam logic [7:0] OFS_TI = 8'h0C;
	localparam logic [7:0] OFS_TD = 8'h10;
	localparam logic [7:0] OFS_UPPER = 8'h14;
	localparam logic [7:0] OFS_LOWER = 8'h18;
	localparam logic [7:0] OFS_MAXF = 8'h1C;
	localparam logic [7:0] OFS_SLP_DLY = 8'h20;
	localparam logic [7:0] OFS_SLP_FRQ = 8'h24;
	localparam logic [7:0] OFS_WAKE = 8'h28;
	localparam logic [7:0] OFS_BOOST = 8'h2C;
	localparam logic [7:0] OFS_FUNC = 8'h30;
	localparam logic [7:0] OFS_STATUS = 8'h34;
	localparam logic [7:0] OFS_FREQ = 8'h38;
	localparam logic [7:0] OFS_FBK = 8'h3C;
	localparam logic [7:0] OFS_STAGE = 8'h40;
	// ****************
	// ctrl field positions
	// ****************
	localparam int CTRL_EN = 0;
	localparam int CTRL_UNIT = 1;
	localparam int CTRL_MODE = 2;
	localparam int CTRL_FBS = 3;
	localparam int CTRL_CM = 5;
	localparam int CTRL_SRC = 8;
	// ****************
	// reset values (hz in 0.01, percent in 0.1, gain in 0.1 %, times as noted)
	// ****************
	localparam logic [31:0] CTRL_RST = 32'h0000_0030;
	localparam logic [15:0] KP_RST = 16'h0BB8;
	localparam logic [15:0] TI_RST = 16'h0064;
	localparam logic [15:0] TD_RST = 16'h0000;
	localparam logic [15:0] UPPER_RST = 16'h1770;
	localparam logic [15:0] LOWER_RST = 16'h0032;
	localparam logic [15:0] MAXF_RST = 16'h1770;
	localparam logic [15:0] SLP_DLY_RST = 16'h0258;
	localparam logic [15:0] SLP_FRQ_RST = 16'h0000;
	localparam logic [15:0] WAKE_RST = 16'h015E;
	// ****************
	// codes and scales
	// ****************
	localparam logic [1:0] FBS_I2_CUR = 2'h0;
	localparam logic [1:0] FBS_I2_VOLT = 2'h1;
	localparam logic [1:0] FBS_V1 = 2'h2;
	localparam logic [1:0] FBS_SERIAL = 2'h3;
	localparam logic [1:0] CM_SENSORLESS = 2'h2;
	localparam logic [4:0] FUNC_BYPASS = 5'h15;
	localparam logic [3:0] SRC_UPDOWN = 4'hA;
	localparam logic [15:0] SERIAL_FB_ADDR = 16'h001E;
	localparam logic [15:0] PCT_FULL = 16'h03E8;
	localparam int NUM_PINS = 5;
	// sample period and its cycle count at the system clock
	localparam int SAMPLE_US = 1000;
	localparam int CLK_MHZ = 100;
	localparam int TICK_CYCLES = SAMPLE_US * CLK_MHZ;
	localparam int TI_MS_PER_LSB = 10;
	localparam int TD_MS_PER_LSB = 10;
	localparam int SLP_MS_PER_LSB = 100;
	typedef enum logic [1:0] {
		ST_STOP,
		ST_RUN,
		ST_SLEEP
	} dpc_state_type;
endpackage : dpc_pkg

//--- rtl/dpc_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module dpc_sync #(
	parameter int WIDTH = 1
) (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic [WIDTH-1:0] async_i,
	output logic [WIDTH-1:0] sync_o
);
	logic [WIDTH-1:0] meta_r;

	// meta_r feeds only the second stage
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			meta_r <= '0;
			sync_o <= '0;
		end else if (ce_i) begin
			meta_r <= async_i;
			sync_o <= meta_r;
		end
	end
endmodule : dpc_sync

//--- rtl/dpc_top.sv
// pid speed controller: apb registers, feedback select, pid, limits, sleep
//
// Notes on behaviour
// - pid and its settings act only while the enable bit is 1
// - control method 2 raises start torque and compensates slip
// - manual torque boost is ignored while control method is 2
// - feedback source 0 i2 current, 1 i2 voltage, 2 v1, 3 serial; reset 2
// - serial feedback in 0.1 % steps at address 0x001e, any unit
// - proportional term is error times gain percent; default 300.0
// - constant 100 % error gives 100 % output after one integral time
// - error sampled every 1 ms; derivative scales with derivative time
// - normal mode pid output clamped to upper and lower limits; lower never above upper
// - unit select 0 means hertz, 1 means percent
// - mode 0 normal uses pid result as frequency, mode 1 process
// - input with function 21 on bypasses pid; normal mode runs command frequency
// - bypass in percent units converts percent command to frequency
// - normal mode output unipolar; pid result held within the limits, bypass command not
// - 100.0 percent equals the maximum frequency
// - process output is main reference plus pid stage; source 10 excluded
// - process pid stage is signed and bounded by the upper limit
// - process sum clamped between lower limit and maximum frequency
// - process mode with bypass outputs the main reference alone
// - sleep after output stays at or below sleep frequency for the sleep delay
// - asleep, wake when deviation exceeds the wake-up level
// - stop command cancels sleep entry and wake
`timescale 1ns/1ps
module dpc_top
	import dpc_pkg::*;
#(
	parameter int TICK = TICK_CYCLES,
	parameter int ADC_W = 12
) (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic ser_wr_i,
	input wire logic ser_rd_i,
	input wire logic [15:0] ser_addr_i,
	input wire logic [15:0] ser_wdata_i,
	output logic [15:0] ser_rdata_o,
	input wire logic [ADC_W-1:0] secondary_analog_input_cur_i,
	input wire logic [ADC_W-1:0] secondary_analog_input_volt_i,
	input wire logic [ADC_W-1:0] primary_voltage_input_i,
	input wire logic [15:0] main_ref_i,
	input wire logic [NUM_PINS-1:0] mf_pin_i,
	input wire logic run_pin_i,
	output logic [15:0] freq_out_o,
	output logic sleep_o,
	output logic auto_boost_o,
	output logic slip_comp_o,
	output logic manual_boost_o
);
	import dpc_pkg::*;

	// ****************
	// registers
	// ****************
	logic [31:0] ctrl_r;
	logic [15:0] setpoint_value_r;
	logic [15:0] proportional_gain_r;
	logic [15:0] integral_time_r;
	logic [15:0] derivative_time_r;
	logic [15:0] output_upper_limit_r;
	logic [15:0] output_lower_limit_r;
	logic [15:0] max_frequency_r;
	logic [15:0] sleep_delay_time_r;
	logic [15:0] sleep_frequency_r;
	logic [15:0] wake_up_level_r;
	logic manual_boost_r;
	logic [NUM_PINS*5-1:0] input_function_assign_r;
	logic [15:0] ser_fb_r;
	logic [15:0] feedback_value_r;
	logic signed [17:0] stage_r;

	logic pid_enable_select;
	logic pid_unit_select;
	logic pid_mode_select;
	logic [1:0] feedback_source_select;
	logic [1:0] control_method_select;
	logic [3:0] setpoint_source_select;
	assign pid_enable_select = ctrl_r[CTRL_EN];
	assign pid_unit_select = ctrl_r[CTRL_UNIT];
	assign pid_mode_select = ctrl_r[CTRL_MODE];
	assign feedback_source_select = ctrl_r[CTRL_FBS+:2];
	assign control_method_select = ctrl_r[CTRL_CM+:2];
	assign setpoint_source_select = ctrl_r[CTRL_SRC+:4];

	// ****************
	// pin synchronisers
	// ****************
	logic [NUM_PINS:0] pins_s;
	dpc_sync #(
		.WIDTH(NUM_PINS + 1)
	) u_sync (
		.sys_clk_i(sys_clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.async_i({run_pin_i, mf_pin_i}),
		.sync_o(pins_s)
	);
	logic run_s;
	assign run_s = pins_s[NUM_PINS];

	// bypass when any pin assigned the bypass function is on
	logic [NUM_PINS-1:0] byp_hit;
	genvar g;
	generate
		for (g = 0; g < NUM_PINS; g++) begin : g_pin
			assign byp_hit[g] = pins_s[g] &&
				(input_function_assign_r[g*5+:5] == FUNC_BYPASS);
		end
	endgenerate
	logic bypass;
	assign bypass = |byp_hit;

	// ****************
	// apb slave
	// ****************
	logic acc;
	logic wr_en;
	assign acc = psel && penable && !pready;
	assign wr_en = acc && pwrite;
	logic hit;
	always_comb begin
		hit = 1'b1;
		unique case (paddr)
			OFS_CTRL, OFS_SETPOINT, OFS_KP, OFS_TI, OFS_TD: hit = 1'b1;
			OFS_UPPER, OFS_LOWER, OFS_MAXF, OFS_SLP_DLY: hit = 1'b1;
			OFS_SLP_FRQ, OFS_WAKE, OFS_BOOST, OFS_FUNC: hit = 1'b1;
			OFS_STATUS, OFS_FREQ, OFS_FBK, OFS_STAGE: hit = 1'b1;
			default: hit = 1'b0;
		endcase
	end

	dpc_state_type state_r;

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			ctrl_r <= CTRL_RST;
			setpoint_value_r <= '0;
			proportional_gain_r <= KP_RST;
			integral_time_r <= TI_RST;
			derivative_time_r <= TD_RST;
			output_upper_limit_r <= UPPER_RST;
			output_lower_limit_r <= LOWER_RST;
			max_frequency_r <= MAXF_RST;
			sleep_delay_time_r <= SLP_DLY_RST;
			sleep_frequency_r <= SLP_FRQ_RST;
			wake_up_level_r <= WAKE_RST;
			manual_boost_r <= 1'b0;
			input_function_assign_r <= '0;
		end else if (ce_i && wr_en) begin
			unique case (paddr)
				OFS_CTRL: ctrl_r <= {20'h0_0000, pwdata[11:0]};
				OFS_SETPOINT: setpoint_value_r <= pwdata[15:0];
				OFS_KP: proportional_gain_r <= pwdata[15:0];
				OFS_TI: integral_time_r <= pwdata[15:0];
				OFS_TD: derivative_time_r <= pwdata[15:0];
				OFS_UPPER: output_upper_limit_r <= (pwdata[15:0] < output_lower_limit_r) ?
					output_lower_limit_r : pwdata[15:0];
				OFS_LOWER: output_lower_limit_r <= (pwdata[15:0] > output_upper_limit_r) ?
					output_upper_limit_r : pwdata[15:0];
				OFS_MAXF: max_frequency_r <= pwdata[15:0];
				OFS_SLP_DLY: sleep_delay_time_r <= pwdata[15:0];
				OFS_SLP_FRQ: sleep_frequency_r <= pwdata[15:0];
				OFS_WAKE: wake_up_level_r <= pwdata[15:0];
				OFS_BOOST: manual_boost_r <= pwdata[0];
				OFS_FUNC: input_function_assign_r <= pwdata[NUM_PINS*5-1:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= '0;
		end else if (ce_i) begin
			pready <= acc;
			pslverr <= acc && !hit;
			if (acc && !pwrite) begin
				unique case (paddr)
					OFS_CTRL: prdata <= ctrl_r;
					OFS_SETPOINT: prdata <= {16'h0000, setpoint_value_r};
					OFS_KP: prdata <= {16'h0000, proportional_gain_r};
					OFS_TI: prdata <= {16'h0000, integral_time_r};
					OFS_TD: prdata <= {16'h0000, derivative_time_r};
					OFS_UPPER: prdata <= {16'h0000, output_upper_limit_r};
					OFS_LOWER: prdata <= {16'h0000, output_lower_limit_r};
					OFS_MAXF: prdata <= {16'h0000, max_frequency_r};
					OFS_SLP_DLY: prdata <= {16'h0000, sleep_delay_time_r};
					OFS_SLP_FRQ: prdata <= {16'h0000, sleep_frequency_r};
					OFS_WAKE: prdata <= {16'h0000, wake_up_level_r};
					OFS_BOOST: prdata <= {31'h0000_0000, manual_boost_r};
					OFS_FUNC: prdata <= {7'h00, input_function_assign_r};
					OFS_STATUS: prdata <= {28'h000_0000, bypass, run_s,
						state_r == ST_RUN, state_r == ST_SLEEP};
					OFS_FREQ: prdata <= {16'h0000, freq_out_o};
					OFS_FBK: prdata <= {16'h0000, feedback_value_r};
					OFS_STAGE: prdata <= {{14{stage_r[17]}}, stage_r};
					default: prdata <= '0;
				endcase
			end
		end
	end

	// ****************
	// serial feedback port
	// ****************
	// always 0.1 % steps, whatever the unit select says
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			ser_fb_r <= '0;
			ser_rdata_o <= '0;
		end else if (ce_i) begin
			if (ser_wr_i && ser_addr_i == SERIAL_FB_ADDR)
				ser_fb_r <= (ser_wdata_i > PCT_FULL) ? PCT_FULL : ser_wdata_i;
			if (ser_rd_i)
				ser_rdata_o <= (ser_addr_i == SERIAL_FB_ADDR) ? ser_fb_r : 16'h0000;
		end
	end

	// ****************
	// feedback and error
	// ****************
	logic [ADC_W-1:0] adc_sel;
	logic [15:0] fb_pct;
	logic [15:0] fb_unit;
	logic [31:0] fb_tmp;
	always_comb begin
		unique case (feedback_source_select)
			FBS_I2_CUR: adc_sel = secondary_analog_input_cur_i;
			FBS_I2_VOLT: adc_sel = secondary_analog_input_volt_i;
			FBS_V1: adc_sel = primary_voltage_input_i;
			FBS_SERIAL: adc_sel = '0;
		endcase
		fb_tmp = (32'(adc_sel) * 32'(PCT_FULL)) >> ADC_W;
		fb_pct = (feedback_source_select == FBS_SERIAL) ? ser_fb_r : fb_tmp[15:0];
		fb_tmp = (32'(fb_pct) * 32'(max_frequency_r)) / 32'(PCT_FULL);
		fb_unit = pid_unit_select ? fb_pct : fb_tmp[15:0];
	end

	logic signed [17:0] err;
	logic signed [17:0] err_prev_r;
	logic signed [31:0] err_pct;
	logic [15:0] maxf_nz;
	assign maxf_nz = (max_frequency_r == 16'h0000) ? 16'h0001 : max_frequency_r;
	assign err = $signed({2'b00, setpoint_value_r}) - $signed({2'b00, fb_unit});
	assign err_pct = pid_unit_select ? 32'(err) :
		(32'(err) * $signed(32'(PCT_FULL))) / $signed({16'h0000, maxf_nz});

	// ****************
	// pid term arithmetic
	// ****************
	localparam logic signed [31:0] ISUM_MAX = 32'sh0100_0000;
	logic signed [31:0] isum_r;
	logic signed [31:0] isum_nxt;
	logic signed [31:0] p_term;
	logic signed [31:0] i_term;
	logic signed [31:0] d_term;
	logic signed [31:0] u_unit;
	logic signed [31:0] u_hz;
	logic [31:0] ti_ms;
	always_comb begin
		ti_ms = 32'(integral_time_r) * 32'(TI_MS_PER_LSB);
		if (ti_ms == 32'h0000_0000)
			ti_ms = 32'h0000_0001;
		p_term = (32'(err) * $signed({16'h0000, proportional_gain_r})) /
			32'sd1000;
		isum_nxt = isum_r + 32'(err);
		if (isum_nxt > ISUM_MAX)
			isum_nxt = ISUM_MAX;
		if (isum_nxt < -ISUM_MAX)
			isum_nxt = -ISUM_MAX;
		i_term = isum_r / $signed(ti_ms);
		d_term = 32'(err - err_prev_r) *
			$signed(32'(derivative_time_r) * 32'(TD_MS_PER_LSB));
		u_unit = p_term + i_term + d_term;
		u_hz = pid_unit_select ?
			(u_unit * $signed({16'h0000, max_frequency_r})) / 32'sd1000 : u_unit;
	end

	// command frequency in hz, converting a percent setpoint first
	logic [31:0] cmd_tmp;
	logic [15:0] cmd_hz;
	assign cmd_tmp = (32'(setpoint_value_r) * 32'(max_frequency_r)) / 32'(PCT_FULL);
	assign cmd_hz = pid_unit_select ? cmd_tmp[15:0] : setpoint_value_r;

	// main reference drops out when the up/down source is selected
	logic [15:0] main_ref;
	assign main_ref = (setpoint_source_select == SRC_UPDOWN) ? 16'h0000 : main_ref_i;

	// ****************
	// output shaping
	// ****************
	logic signed [31:0] upper_s;
	logic signed [31:0] lower_s;
	logic signed [31:0] maxf_s;
	logic signed [31:0] stage;
	logic signed [31:0] sum;
	logic [15:0] freq_nxt;
	assign upper_s = $signed({16'h0000, output_upper_limit_r});
	assign lower_s = $signed({16'h0000, output_lower_limit_r});
	assign maxf_s = $signed({16'h0000, max_frequency_r});
	always_comb begin
		stage = u_hz;
		if (stage > upper_s)
			stage = upper_s;
		if (stage < -upper_s)
			stage = -upper_s;
		sum = $signed({16'h0000, main_ref}) + stage;
		if (sum > maxf_s)
			sum = maxf_s;
		if (sum < lower_s)
			sum = lower_s;
		if (!pid_mode_select) begin
			// normal: never negative; pid result held in the limits, bypass command not
			if (bypass)
				freq_nxt = cmd_hz;
			else if (u_hz > upper_s)
				freq_nxt = output_upper_limit_r;
			else if (u_hz < lower_s)
				freq_nxt = output_lower_limit_r;
			else
				freq_nxt = u_hz[15:0];
		end else begin
			freq_nxt = bypass ? main_ref : sum[15:0];
		end
	end

	// ****************
	// sample tick
	// ****************
	logic [31:0] tick_cnt_r;
	logic tick;
	assign tick = (tick_cnt_r == 32'(TICK - 1));
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i)
			tick_cnt_r <= '0;
		else if (ce_i)
			tick_cnt_r <= tick ? 32'h0000_0000 : tick_cnt_r + 32'h0000_0001;
	end

	// ****************
	// run, sleep and output state
	// ****************
	logic [31:0] slp_cnt_r;
	logic [31:0] slp_lim;
	logic [31:0] err_abs;
	assign slp_lim = 32'(sleep_delay_time_r) * 32'(SLP_MS_PER_LSB);
	assign err_abs = err_pct[31] ? 32'(-err_pct) : 32'(err_pct);

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_r <= ST_STOP;
			slp_cnt_r <= '0;
			isum_r <= '0;
			err_prev_r <= '0;
			stage_r <= '0;
			freq_out_o <= '0;
			feedback_value_r <= '0;
		end else if (ce_i) begin
			if (!run_s) begin
				// a stop drops any sleep in progress
				state_r <= ST_STOP;
				slp_cnt_r <= '0;
				isum_r <= '0;
				freq_out_o <= '0;
			end else if (!pid_enable_select) begin
				// pid idle: settings ignored, main reference passes through
				state_r <= ST_RUN;
				slp_cnt_r <= '0;
				isum_r <= '0;
				err_prev_r <= '0;
				freq_out_o <= main_ref;
			end else if (tick) begin
				feedback_value_r <= fb_unit;
				err_prev_r <= err;
				unique case (state_r)
					ST_STOP: begin
						state_r <= ST_RUN;
						slp_cnt_r <= '0;
					end
					ST_RUN: begin
						isum_r <= isum_nxt;
						stage_r <= stage[17:0];
						freq_out_o <= freq_nxt;
						if (!bypass && freq_nxt <= sleep_frequency_r) begin
							if (slp_cnt_r + 32'h0000_0001 >= slp_lim) begin
								state_r <= ST_SLEEP;
								freq_out_o <= '0;
								slp_cnt_r <= '0;
							end else begin
								slp_cnt_r <= slp_cnt_r + 32'h0000_0001;
							end
						end else begin
							slp_cnt_r <= '0;
						end
					end
					ST_SLEEP: begin
						// keep watching the deviation while asleep
						freq_out_o <= '0;
						isum_r <= '0;
						if (err_abs > 32'(wake_up_level_r))
							state_r <= ST_RUN;
					end
				endcase
			end
		end
	end

	// ****************
	// control method outputs
	// ****************
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			sleep_o <= 1'b0;
			auto_boost_o <= 1'b0;
			slip_comp_o <= 1'b0;
			manual_boost_o <= 1'b0;
		end else if (ce_i) begin
			sleep_o <= (state_r == ST_SLEEP);
			auto_boost_o <= (control_method_select == CM_SENSORLESS);
			slip_comp_o <= (control_method_select == CM_SENSORLESS) ||
				(control_method_select == 2'h1);
			manual_boost_o <= manual_boost_r &&
				(control_method_select != CM_SENSORLESS);
		end
	end
endmodule : dpc_top

//--- verification/dpc_chk.sv
// checker: port-level relations of the pid speed controller
`timescale 1ns/1ps
module dpc_chk
	import dpc_pkg::*;
#(
	parameter int TICK = 100
) (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic ser_wr_i,
	input wire logic ser_rd_i,
	input wire logic [15:0] ser_addr_i,
	input wire logic [15:0] ser_wdata_i,
	input wire logic [15:0] ser_rdata_o,
	input wire logic run_pin_i,
	input wire logic [15:0] freq_out_o,
	input wire logic sleep_o,
	input wire logic auto_boost_o,
	input wire logic slip_comp_o,
	input wire logic manual_boost_o
);
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (rst_i);
	// ****************
	// helpers
	// ****************
	// counts stop time; saturates so it never wraps on long stops
	int stop_cnt_r;
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			stop_cnt_r <= 0;
		end else if (run_pin_i) begin
			stop_cnt_r <= 0;
		end else if (stop_cnt_r < TICK + 8) begin
			stop_cnt_r <= stop_cnt_r + 1;
		end
	end
	sequence s_fb_wr;
		ser_wr_i && ser_addr_i == SERIAL_FB_ADDR;
	endsequence
	sequence s_fb_rd;
		ser_rd_i && ser_addr_i == SERIAL_FB_ADDR;
	endsequence
	// ****************
	// assertions
	// ****************
	a_apb_answer: assert property (psel && penable && !pready && ce_i |=> pready)
		else $error("apb access not answered after one wait state");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	a_ready_cause: assert property (pready |-> $past(psel && penable))
		else $error("pready without access");
	a_err_ready: assert property (pslverr |-> pready)
		else $error("pslverr outside answer");
	a_auto_slip: assert property (auto_boost_o |-> slip_comp_o)
		else $error("auto boost without slip compensation");
	a_boost_excl: assert property (manual_boost_o |-> !auto_boost_o)
		else $error("manual boost active with sensorless method");
	a_sleep_zero: assert property (sleep_o && $past(sleep_o) |-> freq_out_o == 16'h0000)
		else $error("output not stopped while asleep");
	a_stop_zero: assert property (stop_cnt_r == TICK + 8 |-> freq_out_o == 16'h0000 && !sleep_o)
		else $error("output or sleep active after stop");
	a_ser_other: assert property (ser_rd_i && ser_addr_i != SERIAL_FB_ADDR |=> ser_rdata_o == 16'h0000)
		else $error("serial read of other address not zero");
	a_ser_back: assert property (s_fb_wr ##1 s_fb_rd |=> ser_rdata_o ==
		(($past(ser_wdata_i, 2) > 16'h03E8) ? 16'h03E8 : $past(ser_wdata_i, 2)))
		else $error("serial feedback read back wrong");
endmodule : dpc_chk

//--- verification/dpc_plant.sv
// partner model: process sensors, main reference and command pins
`timescale 1ns/1ps
module dpc_plant
	import dpc_pkg::*;
(
	input wire logic sys_clk_i,
	input wire logic [11:0] pv_code_i,
	input wire logic [1:0] pv_sel_i,
	input wire logic [15:0] ref_i,
	input wire logic byp_i,
	input wire logic run_i,
	output logic [11:0] cur_o,
	output logic [11:0] volt_o,
	output logic [11:0] v1_o,
	output logic [15:0] main_ref_o,
	output logic [NUM_PINS-1:0] mf_pin_o,
	output logic run_pin_o
);
	// ****************
	// sensors and pins
	// ****************
	// only the wired sensor carries the process value; the others read empty
	always_ff @(posedge sys_clk_i) begin
		cur_o <= (pv_sel_i == 2'h0) ? pv_code_i : 12'h000;
		volt_o <= (pv_sel_i == 2'h1) ? pv_code_i : 12'h000;
		v1_o <= (pv_sel_i == 2'h2) ? pv_code_i : 12'h000;
		main_ref_o <= ref_i;
		mf_pin_o <= NUM_PINS'(byp_i);
		run_pin_o <= run_i;
	end
endmodule : dpc_plant

//--- verification/tb.sv
// testbench: pid speed controller against the sensor model
`timescale 1ns/1ps
module tb;
	import dpc_pkg::*;
	localparam int TK = 100;
	localparam logic [7:0] RA [10] = '{OFS_CTRL, OFS_KP, OFS_TI, OFS_TD, OFS_UPPER,
		OFS_LOWER, OFS_MAXF, OFS_SLP_DLY, OFS_SLP_FRQ, OFS_WAKE};
	localparam logic [31:0] RV [10] = '{32'h30, 32'hBB8, 32'h64, 32'h0, 32'h1770,
		32'h32, 32'h1770, 32'h258, 32'h0, 32'h15E};
	logic sys_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, er;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd, ev;
	logic ser_wr_i = 1'b0, ser_rd_i = 1'b0, byp = 1'b0, run = 1'b0, run_pin;
	logic [15:0] ser_addr_i = 16'h0, ser_wdata_i = 16'h0, ser_rdata_o, rf = 16'h0;
	logic [15:0] main_ref, freq_out_o;
	logic [11:0] pv = 12'h000, cur, volt, v1;
	logic [1:0] psl = 2'h2;
	logic [NUM_PINS-1:0] mf_pin;
	logic sleep_o, auto_boost_o, slip_comp_o, manual_boost_o;
	logic [31:0] rnd = 32'h0001_00FF;
	int bad_count = 0, check_count = 0;
	always #5 sys_clk_i = ~sys_clk_i;
	dpc_plant u_plant (.sys_clk_i(sys_clk_i), .pv_code_i(pv), .pv_sel_i(psl), .ref_i(rf),
		.byp_i(byp), .run_i(run), .cur_o(cur), .volt_o(volt), .v1_o(v1),
		.main_ref_o(main_ref), .mf_pin_o(mf_pin), .run_pin_o(run_pin));
	dpc_top #(.TICK(TK)) DUT (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .ce_i(1'b1),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .ser_wr_i(ser_wr_i),
		.ser_rd_i(ser_rd_i), .ser_addr_i(ser_addr_i), .ser_wdata_i(ser_wdata_i),
		.ser_rdata_o(ser_rdata_o), .secondary_analog_input_cur_i(cur),
		.secondary_analog_input_volt_i(volt), .primary_voltage_input_i(v1),
		.main_ref_i(main_ref), .mf_pin_i(mf_pin), .run_pin_i(run_pin),
		.freq_out_o(freq_out_o), .sleep_o(sleep_o), .auto_boost_o(auto_boost_o),
		.slip_comp_o(slip_comp_o), .manual_boost_o(manual_boost_o));
	// ****************
	// helpers
	// ****************
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	function automatic logic [31:0] ctrl(input int en, input int u, input int m,
		input int f, input int c);
		return 32'(en + u * 2 + m * 4 + f * 8 + c * 32);
	endfunction : ctrl
	// percent in 0.1 steps to hz in 0.01 steps, full scale at max frequency
	function automatic logic [31:0] pct2hz(input int p, input int mx);
		return 32'(p * mx / 1000);
	endfunction : pct2hz
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk_i);
		penable <= 1'b1;
		do begin
			@(posedge sys_clk_i);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) bad_count++;
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge sys_clk_i);
	endtask : apb
	// write then read back at once, as the serial master does
	task automatic ser(input logic [15:0] a, input logic [15:0] d);
		ser_addr_i <= a;
		ser_wdata_i <= d;
		ser_wr_i <= 1'b1;
		@(posedge sys_clk_i);
		ser_wr_i <= 1'b0;
		ser_rd_i <= 1'b1;
		@(posedge sys_clk_i);
		ser_rd_i <= 1'b0;
		@(posedge sys_clk_i);
	endtask : ser
	task automatic ticks(input int n);
		repeat (n * TK) @(posedge sys_clk_i);
	endtask : ticks
	task automatic finish_test;
		$display("checks=%0d errors=%0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : finish_test
	initial begin
		repeat (60000) @(posedge sys_clk_i);
		bad_count++;
		finish_test();
	end
	// ****************
	// scenarios
	// ****************
	initial begin
		repeat (16) @(posedge sys_clk_i);
		rst_i <= 1'b0;
		@(posedge sys_clk_i);
		for (int i = 0; i < 10; i++) begin
			apb(1'b0, RA[i], 32'h0);
			chk(rd, RV[i]);
		end
		apb(1'b0, 8'hFC, 32'h0);
		chk({rd[30:0], er}, 32'h1);
		apb(1'b1, OFS_UPPER, 32'h14);
		apb(1'b0, OFS_UPPER, 32'h0);
		chk(rd, 32'h32);
		apb(1'b1, OFS_BOOST, 32'h1);
		for (int m = 0; m < 3; m++) begin
			apb(1'b1, OFS_CTRL, ctrl(0, 0, 0, 2, m));
			repeat (2) @(posedge sys_clk_i);
			chk(32'({auto_boost_o, slip_comp_o, manual_boost_o}), 32'({m == 2, m != 0, m != 2}));
		end
		run <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			rnd = lfsr(rnd);
			ev = rnd % 6001;
			rf <= ev[15:0];
			ticks(1);
			chk(32'(freq_out_o), ev);
		end
		for (int i = 0; i < 3; i++) begin
			rnd = lfsr(rnd);
			ev = rnd % 1001;
			ser(SERIAL_FB_ADDR, ev[15:0]);
			chk(32'(ser_rdata_o), ev);
		end
		ser(SERIAL_FB_ADDR, 16'h05DC);
		chk(32'(ser_rdata_o), 32'h3E8);
		ser(16'h001F, 16'h0005);
		chk(32'(ser_rdata_o), 32'h0);
		pv <= 12'h800;
		for (int s = 0; s < 4; s++) begin
			psl <= 2'(s);
			apb(1'b1, OFS_CTRL, ctrl(1, 1, 0, s, 1));
			ser(SERIAL_FB_ADDR, (s == 3) ? 16'h01F4 : 16'h0000);
			ticks(2);
			apb(1'b0, OFS_FBK, 32'h0);
			chk(rd, 32'h1F4);
		end
		psl <= 2'h2;
		apb(1'b1, OFS_CTRL, ctrl(1, 0, 0, 2, 1));
		apb(1'b1, OFS_TI, 32'hC80);
		apb(1'b1, OFS_UPPER, 32'hBB8);
		ticks(4);
		apb(1'b0, OFS_FBK, 32'h0);
		chk(rd, pct2hz(500, 6000));
		chk(32'(freq_out_o), 32'h32);
		apb(1'b1, OFS_SETPOINT, 32'h1770);
		pv <= 12'h000;
		ticks(4);
		chk(32'(freq_out_o), 32'hBB8);
		apb(1'b1, OFS_MAXF, 32'hFA0);
		rf <= 16'h0DAC;
		apb(1'b1, OFS_CTRL, ctrl(1, 0, 1, 2, 1));
		ticks(4);
		chk(32'(freq_out_o), 32'hFA0);
		apb(1'b1, OFS_CTRL, ctrl(1, 0, 1, 2, 1) | 32'h0000_0A00);
		ticks(2);
		chk(32'(freq_out_o), 32'hBB8);
		apb(1'b1, OFS_CTRL, ctrl(1, 0, 1, 2, 1));
		apb(1'b1, OFS_FUNC, 32'h15);
		byp <= 1'b1;
		ticks(2);
		chk(32'(freq_out_o), 32'hDAC);
		apb(1'b1, OFS_MAXF, 32'h1770);
		apb(1'b1, OFS_SETPOINT, 32'h1F4);
		apb(1'b1, OFS_CTRL, ctrl(1, 1, 0, 2, 1));
		ticks(2);
		chk(32'(freq_out_o), pct2hz(500, 6000));
		byp <= 1'b0;
		apb(1'b1, OFS_SLP_FRQ, 32'h12C);
		apb(1'b1, OFS_SLP_DLY, 32'h1);
		apb(1'b1, OFS_SETPOINT, 32'h0);
		ticks(50);
		chk(32'(sleep_o), 32'h0);
		ticks(70);
		chk(32'({sleep_o, freq_out_o}), 32'h1_0000);
		apb(1'b1, OFS_SETPOINT, 32'h1F4);
		ticks(3);
		chk(32'(sleep_o), 32'h0);
		apb(1'b1, OFS_SETPOINT, 32'h0);
		run <= 1'b0;
		ticks(115);
		chk(32'({sleep_o, freq_out_o}), 32'h0);
		finish_test();
	end
endmodule : tb
bind dpc_top dpc_chk #(.TICK(TICK)) u_chk (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .ce_i(ce_i),
	.psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr), .ser_wr_i(ser_wr_i),
	.ser_rd_i(ser_rd_i), .ser_addr_i(ser_addr_i), .ser_wdata_i(ser_wdata_i),
	.ser_rdata_o(ser_rdata_o), .run_pin_i(run_pin_i), .freq_out_o(freq_out_o),
	.sleep_o(sleep_o), .auto_boost_o(auto_boost_o), .slip_comp_o(slip_comp_o),
	.manual_boost_o(manual_boost_o));
